// [rtl/cso_config.sv]
`timescale 1ns/100ps
module cso_config #(
	parameter logic EXT_CLAMP_AUTO_HIGH = 1'b1,
	parameter logic EXT_COAST_AUTO_HIGH = 1'b1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rd_data_o,
	input wire cso_pkg::cso_chan_t chan0_i,
	input wire cso_pkg::cso_chan_t chan1_i,
	input wire logic ext_clamp_i,
	input wire logic ext_freewheel_i,
	input wire logic vsync_i,
	input wire logic regen_sync_i,
	input wire logic filt_sync_i,
	output logic clamp_o,
	output logic [2:0] clamp_level_o,
	output logic pll_freewheel_o,
	output logic auto_offset_en_o,
	output logic auto_offset_update_o,
	output logic [4:0] slicer_threshold_o,
	output logic embedded_sync_output_o,
	output logic channel_sel_o
);
	// ==========================================
	// Register file
	logic [7:0] freewheel_and_clamp_control;
	logic [7:0] clamp_placement;
	logic [7:0] clamp_duration;
	logic [7:0] clamp_and_offset_control;
	logic [7:0] factory_test_reg;
	logic [7:0] slicer_control;
	logic [7:0] power_and_channel_control;
	logic [7:0] next_rd_data;

	// Fields stored as written, effective next cycle
	// (R21) writable readable bank
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			freewheel_and_clamp_control <= cso_pkg::RST_FREEWHEEL_CLAMP;
			clamp_placement <= cso_pkg::RST_CLAMP_PLACEMENT;
			clamp_duration <= cso_pkg::RST_CLAMP_DURATION;
			clamp_and_offset_control <= cso_pkg::RST_CLAMP_OFFSET;
			factory_test_reg <= cso_pkg::RST_FACTORY_TEST;
			slicer_control <= cso_pkg::RST_SLICER;
			// (R20) automatic channel after reset
			power_and_channel_control <= cso_pkg::RST_POWER_CHANNEL;
		end else if (ce_i && wr_i) begin
			unique case (addr_i)
				cso_pkg::ADDR_FREEWHEEL_CLAMP: freewheel_and_clamp_control <= wr_data_i;
				cso_pkg::ADDR_CLAMP_PLACEMENT: clamp_placement <= wr_data_i;
				cso_pkg::ADDR_CLAMP_DURATION: clamp_duration <= wr_data_i;
				cso_pkg::ADDR_CLAMP_OFFSET: clamp_and_offset_control <= wr_data_i;
				cso_pkg::ADDR_FACTORY_TEST: factory_test_reg <= wr_data_i;
				cso_pkg::ADDR_SLICER: slicer_control <= wr_data_i;
				cso_pkg::ADDR_POWER_CHANNEL: power_and_channel_control <= wr_data_i;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		unique case (addr_i)
			cso_pkg::ADDR_FREEWHEEL_CLAMP: next_rd_data = freewheel_and_clamp_control;
			cso_pkg::ADDR_CLAMP_PLACEMENT: next_rd_data = clamp_placement;
			cso_pkg::ADDR_CLAMP_DURATION: next_rd_data = clamp_duration;
			cso_pkg::ADDR_CLAMP_OFFSET: next_rd_data = clamp_and_offset_control;
			cso_pkg::ADDR_FACTORY_TEST: next_rd_data = factory_test_reg;
			cso_pkg::ADDR_SLICER: next_rd_data = slicer_control;
			cso_pkg::ADDR_POWER_CHANNEL: next_rd_data = power_and_channel_control;
			default: next_rd_data = 8'h00;
		endcase
	end

	// Read data valid only the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rd_data_o <= 8'h00;
		end else if (ce_i) begin
			rd_data_o <= rd_i ? next_rd_data : 8'h00;
		end
	end

	// ==========================================
	// Pin synchronisers
	cso_pkg::cso_chan_t ch0_s1, ch0_s2, ch1_s1, ch1_s2;
	logic [2:0] pin_s1, pin_s2;
	logic hsync_q, vsync_q, clamp_q;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ch0_s1 <= '0;
			ch0_s2 <= '0;
			ch1_s1 <= '0;
			ch1_s2 <= '0;
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
		end else if (ce_i) begin
			ch0_s1 <= chan0_i;
			ch0_s2 <= ch0_s1;
			ch1_s1 <= chan1_i;
			ch1_s2 <= ch1_s1;
			pin_s1 <= {ext_clamp_i, ext_freewheel_i, vsync_i};
			pin_s2 <= pin_s1;
		end
	end

	// Level of an external pin in active-high terms
	function automatic logic pol_apply(input logic level, input logic ovr,
			input logic pol, input logic auto_high);
		logic high;
		high = ovr ? pol : auto_high;
		return high ? level : ~level;
	endfunction

	// ==========================================
	// Channel selection
	logic next_channel;

	// (R16) override or automatic choice
	// (R17) programmed bit when both carry syncs
	always_comb begin
		if (power_and_channel_control[cso_pkg::PC_CH_OVR] ||
				(ch0_s2.sync_present && ch1_s2.sync_present)) begin
			next_channel = power_and_channel_control[cso_pkg::PC_CH_SEL];
		end else begin
			next_channel = ~ch0_s2.sync_present & ch1_s2.sync_present;
		end
	end

	cso_pkg::cso_chan_t chan;
	assign chan = channel_sel_o ? ch1_s2 : ch0_s2;

	// ==========================================
	// Internal clamp generator
	cso_pkg::cso_clamp_state_t state;
	logic [7:0] cnt;
	logic trail;
	assign trail = hsync_q & ~chan.hsync;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hsync_q <= 1'b0;
			vsync_q <= 1'b0;
		end else if (ce_i) begin
			hsync_q <= chan.hsync;
			vsync_q <= pin_s2[0];
		end
	end

	// (R05) delay after hsync trailing edge
	// (R06) active for duration count
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= cso_pkg::CLAMP_IDLE;
			cnt <= 8'h00;
		end else if (ce_i) begin
			unique case (state)
				cso_pkg::CLAMP_IDLE: begin
					if (trail && clamp_placement != 8'h00) begin
						state <= cso_pkg::CLAMP_WAIT;
						cnt <= clamp_placement;
					end else if (trail && clamp_duration != 8'h00) begin
						state <= cso_pkg::CLAMP_ACTIVE;
						cnt <= clamp_duration;
					end
				end
				cso_pkg::CLAMP_WAIT: begin
					if (cnt != 8'h01) begin
						cnt <= cnt - 8'h01;
					end else if (clamp_duration != 8'h00) begin
						state <= cso_pkg::CLAMP_ACTIVE;
						cnt <= clamp_duration;
					end else begin
						state <= cso_pkg::CLAMP_IDLE;
					end
				end
				cso_pkg::CLAMP_ACTIVE: begin
					if (cnt != 8'h01) begin
						cnt <= cnt - 8'h01;
					end else begin
						state <= cso_pkg::CLAMP_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Clamp, freewheel and level outputs
	logic ext_clamp_act, ext_coast_act, next_clamp;
	// (R07) automatic or programmed polarity
	// (R08) programmed clamp polarity
	assign ext_clamp_act = pol_apply(pin_s2[2], clamp_and_offset_control[cso_pkg::CO_POL_OVR],
		clamp_and_offset_control[cso_pkg::CO_POL], EXT_CLAMP_AUTO_HIGH);
	// (R18) automatic or programmed polarity
	// (R01) programmed freewheel polarity
	assign ext_coast_act = pol_apply(pin_s2[1], freewheel_and_clamp_control[cso_pkg::FC_COAST_OVR],
		freewheel_and_clamp_control[cso_pkg::FC_COAST_POL], EXT_COAST_AUTO_HIGH);
	// (R02) clamp source select
	assign next_clamp = freewheel_and_clamp_control[cso_pkg::FC_CLAMP_SRC] ?
		ext_clamp_act : (state == cso_pkg::CLAMP_ACTIVE);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			clamp_o <= 1'b0;
			clamp_q <= 1'b0;
			pll_freewheel_o <= 1'b0;
			clamp_level_o <= 3'h0;
			channel_sel_o <= 1'b0;
			slicer_threshold_o <= cso_pkg::RST_SLICER[cso_pkg::SL_THR_HI:cso_pkg::SL_THR_LO];
			auto_offset_en_o <= 1'b0;
		end else if (ce_i) begin
			clamp_o <= next_clamp;
			clamp_q <= clamp_o;
			// (R19) freewheel source select
			pll_freewheel_o <= freewheel_and_clamp_control[cso_pkg::FC_COAST_SRC] ?
				ext_coast_act : pin_s2[0];
			// (R03) per-channel clamp level
			clamp_level_o <= freewheel_and_clamp_control[cso_pkg::FC_RED_LVL:cso_pkg::FC_BLUE_LVL];
			channel_sel_o <= next_channel;
			// (R13) slicer threshold field
			slicer_threshold_o <= slicer_control[cso_pkg::SL_THR_HI:cso_pkg::SL_THR_LO];
			// (R09) auto-offset enable
			auto_offset_en_o <= clamp_and_offset_control[cso_pkg::CO_AUTO_EN];
		end
	end

	// ==========================================
	// Embedded sync output
	logic next_esync;
	cso_pkg::cso_sync_src_t sync_src;
	assign sync_src = cso_pkg::cso_sync_src_t'(slicer_control[cso_pkg::SL_SEL_HI:0]);

	// (R15) output source select
	always_comb begin
		unique case (sync_src)
			cso_pkg::SRC_SLICER: next_esync = chan.embedded_sync;
			cso_pkg::SRC_RAW_HSYNC: next_esync = chan.hsync;
			cso_pkg::SRC_REGEN: next_esync = regen_sync_i;
			cso_pkg::SRC_FILTERED: next_esync = filt_sync_i;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			embedded_sync_output_o <= 1'b0;
		end else if (ce_i) begin
			// (R14) output polarity
			embedded_sync_output_o <= slicer_control[cso_pkg::SL_POL] ? next_esync : ~next_esync;
		end
	end

	// ==========================================
	// Auto-offset update pacing
	// Counts finished clamps so the correction loop settles less often
	logic [5:0] clamp_cnt;
	logic clamp_end, vsync_rise, next_update;
	cso_pkg::cso_rate_t rate;
	assign clamp_end = clamp_q & ~clamp_o;
	assign vsync_rise = pin_s2[0] & ~vsync_q;
	assign rate = cso_pkg::cso_rate_t'(
		clamp_and_offset_control[cso_pkg::CO_RATE_HI:cso_pkg::CO_RATE_LO]);

	// (R10) update rate selection
	always_comb begin
		unique case (rate)
			cso_pkg::RATE_EVERY: next_update = clamp_end;
			cso_pkg::RATE_16: next_update = clamp_end && clamp_cnt[3:0] == cso_pkg::RATE_16_LAST[3:0];
			cso_pkg::RATE_64: next_update = clamp_end && clamp_cnt == cso_pkg::RATE_64_LAST;
			cso_pkg::RATE_VSYNC: next_update = vsync_rise;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			clamp_cnt <= 6'h00;
			auto_offset_update_o <= 1'b0;
		end else if (ce_i) begin
			if (clamp_end) begin
				clamp_cnt <= clamp_cnt + 6'h01;
			end
			// (R09) no updates while disabled
			auto_offset_update_o <= clamp_and_offset_control[cso_pkg::CO_AUTO_EN] && next_update;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_wr_then_rd;
		(ce_i && wr_i && addr_i == cso_pkg::ADDR_CLAMP_PLACEMENT) ##1
		(ce_i && rd_i && addr_i == cso_pkg::ADDR_CLAMP_PLACEMENT);
	endsequence

	sequence s_trigger;
		ce_i && state == cso_pkg::CLAMP_IDLE && trail && clamp_placement != 8'h00;
	endsequence

	a_clamp_trigger: assert property (s_trigger |=> state == cso_pkg::CLAMP_WAIT && // R05
		cnt == $past(clamp_placement)) else $error("clamp wait not started");
	a_clamp_wait_end: assert property (ce_i && state == cso_pkg::CLAMP_WAIT && // R05
		cnt == 8'h01 && clamp_duration != 8'h00 |=> state == cso_pkg::CLAMP_ACTIVE)
		else $error("late clamp");
	a_clamp_duration: assert property (ce_i && state == cso_pkg::CLAMP_ACTIVE && // R06
		cnt == 8'h01 |=> state == cso_pkg::CLAMP_IDLE) else $error("clamp too long");
	// External clamp with programmed polarity, checked apart from the helper function
	a_clamp_route: assert property (ce_i && // R02
		freewheel_and_clamp_control[cso_pkg::FC_CLAMP_SRC] &&
		clamp_and_offset_control[cso_pkg::CO_POL_OVR] |=>
		clamp_o == ($past(pin_s2[2]) ~^ $past(clamp_and_offset_control[cso_pkg::CO_POL])))
		else $error("clamp source wrong");
	a_esync_polarity: assert property (ce_i && sync_src == cso_pkg::SRC_REGEN |=> // R14
		embedded_sync_output_o == ($past(regen_sync_i) ~^ $past(slicer_control[cso_pkg::SL_POL])))
		else $error("sync output wrong");
	a_offset_off: assert property (ce_i && !clamp_and_offset_control[cso_pkg::CO_AUTO_EN] // R09
		|=> !auto_offset_update_o) else $error("update while disabled");
	a_rate_every: assert property (ce_i && // R10
		clamp_and_offset_control[cso_pkg::CO_AUTO_EN] &&
		rate == cso_pkg::RATE_EVERY && clamp_end |=> auto_offset_update_o)
		else $error("missed update");
	a_reg_readback: assert property (s_wr_then_rd |=> rd_data_o == $past(wr_data_i, 2)) // R21
		else $error("readback mismatch");
	a_channel_ovr: assert property (ce_i && // R17
		power_and_channel_control[cso_pkg::PC_CH_OVR] |=>
		channel_sel_o == $past(power_and_channel_control[cso_pkg::PC_CH_SEL]))
		else $error("channel override ignored");
endmodule

// [shared/cso_pkg.sv]
// Summary of operation
// (R01) Coast polarity bit picks low or high active external freewheel when overridden.
// (R02) Clamp source bit picks internal hsync-derived clamp or external clamp input.
// (R03) Red, green, blue clamp bits pick ground or midscale clamp level.
// (R04) Software keeps bit 0 of the freewheel and clamp register at zero.
// (R05) Internal clamp starts placement pixel clocks after hsync trailing edge.
// (R06) Internal clamp stays active for clamp duration pixel clocks.
// (R07) Clamp polarity override picks automatic or programmed external clamp polarity.
// (R08) External clamp polarity bit gives active low or high when overridden.
// (R09) Auto-offset enable bit turns automatic offset correction on or off.
// (R10) Update rate runs correction every clamp, 16, 64 clamps, or per vsync.
// (R11) Software writes low three bits of clamp and offset register as 011.
// (R12) Software programs factory test register with all ones.
// (R13) Bits 7:3 of slicer control set the slicer threshold, reset 01111.
// (R14) Polarity bit makes embedded sync output active low or high.
// (R15) Two-bit select routes slicer, raw hsync, regenerated or filtered sync out.
// (R16) Channel override picks automatic or programmed input channel.
// (R17) Channel bit used when overridden or both channels have syncs.
// (R18) Coast polarity override picks automatic or programmed freewheel polarity.
// (R19) Coast source bit picks vsync-derived or external freewheel input.
// (R20) Channel override resets to zero, automatic selection after reset.
// (R21) All fields read back last write and act without a commit.
package cso_pkg;
	localparam logic [7:0] ADDR_FREEWHEEL_CLAMP = 8'h18;
	localparam logic [7:0] ADDR_CLAMP_PLACEMENT = 8'h19;
	localparam logic [7:0] ADDR_CLAMP_DURATION = 8'h1A;
	localparam logic [7:0] ADDR_CLAMP_OFFSET = 8'h1B;
	localparam logic [7:0] ADDR_FACTORY_TEST = 8'h1C;
	localparam logic [7:0] ADDR_SLICER = 8'h1D;
	localparam logic [7:0] ADDR_POWER_CHANNEL = 8'h1E;

	localparam logic [7:0] RST_FREEWHEEL_CLAMP = 8'h20;
	localparam logic [7:0] RST_CLAMP_PLACEMENT = 8'h08;
	localparam logic [7:0] RST_CLAMP_DURATION = 8'h20;
	localparam logic [7:0] RST_CLAMP_OFFSET = 8'h5B;
	localparam logic [7:0] RST_FACTORY_TEST = 8'hFF;
	localparam logic [7:0] RST_SLICER = 8'h78;
	localparam logic [7:0] RST_POWER_CHANNEL = 8'h30;

	// Freewheel and clamp control fields
	localparam int FC_COAST_SRC = 7;
	localparam int FC_COAST_OVR = 6;
	localparam int FC_COAST_POL = 5;
	localparam int FC_CLAMP_SRC = 4;
	localparam int FC_RED_LVL = 3;
	localparam int FC_BLUE_LVL = 1;
	// Clamp and offset fields
	localparam int CO_POL_OVR = 7;
	localparam int CO_POL = 6;
	localparam int CO_AUTO_EN = 5;
	localparam int CO_RATE_HI = 4;
	localparam int CO_RATE_LO = 3;
	// Slicer control fields
	localparam int SL_THR_HI = 7;
	localparam int SL_THR_LO = 3;
	localparam int SL_POL = 2;
	localparam int SL_SEL_HI = 1;
	// Power and channel fields
	localparam int PC_CH_OVR = 7;
	localparam int PC_CH_SEL = 6;

	localparam logic [5:0] RATE_16_LAST = 6'h0F;
	localparam logic [5:0] RATE_64_LAST = 6'h3F;

	typedef enum logic [1:0] {
		RATE_EVERY = 2'b00,
		RATE_16 = 2'b01,
		RATE_64 = 2'b10,
		RATE_VSYNC = 2'b11
	} cso_rate_t;

	typedef enum logic [1:0] {
		SRC_SLICER = 2'b00,
		SRC_RAW_HSYNC = 2'b01,
		SRC_REGEN = 2'b10,
		SRC_FILTERED = 2'b11
	} cso_sync_src_t;

	typedef enum logic [2:0] {
		CLAMP_IDLE = 3'b001,
		CLAMP_WAIT = 3'b010,
		CLAMP_ACTIVE = 3'b100
	} cso_clamp_state_t;

	typedef struct packed {
		logic hsync;
		logic embedded_sync;
		logic sync_present;
	} cso_chan_t;
endpackage

// [testbench/test_clamp_offset_sync_out_config.sv]
`timescale 1ns/100ps
module test_clamp_offset_sync_out_config;
	logic clk_i, reset_i, ce_i, wr_i, rd_i;
	logic [7:0] addr_i, wr_data_i, rd_data_o;
	cso_pkg::cso_chan_t chan0_i, chan1_i;
	logic ext_clamp_i, ext_freewheel_i, vsync_i, regen_sync_i, filt_sync_i;
	logic clamp_o, pll_freewheel_o, auto_offset_en_o, auto_offset_update_o;
	logic embedded_sync_output_o, channel_sel_o;
	logic [2:0] clamp_level_o;
	logic [4:0] slicer_threshold_o;
	logic [7:0] shadow [7];
	logic [7:0] a, d, pl [4], du [4];
	logic [4:0] r, ct [7];
	logic [2:0] ao [4];
	int num_errors = 0, n_compared = 0, cycles = 0, n_upd = 0;
	int dly, wid, base, i, k, nc [4], ne [4];

	cso_config dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.chan0_i(chan0_i), .chan1_i(chan1_i), .ext_clamp_i(ext_clamp_i),
		.ext_freewheel_i(ext_freewheel_i), .vsync_i(vsync_i), .regen_sync_i(regen_sync_i),
		.filt_sync_i(filt_sync_i), .clamp_o(clamp_o), .clamp_level_o(clamp_level_o),
		.pll_freewheel_o(pll_freewheel_o), .auto_offset_en_o(auto_offset_en_o),
		.auto_offset_update_o(auto_offset_update_o), .slicer_threshold_o(slicer_threshold_o),
		.embedded_sync_output_o(embedded_sync_output_o), .channel_sel_o(channel_sel_o));

	initial begin
		clk_i = 1'h0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (auto_offset_update_o === 1'h1) n_upd++;
		if (cycles == 40000) begin
			num_errors++;
			print_verdict();
		end
	end

	// ==========================================
	// Helpers
	task automatic print_verdict;
		if (num_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Keeps the software-side must-write patterns
	function automatic logic [7:0] legal(input logic [7:0] ad, input logic [7:0] v);
		if (ad == 8'h18) return {v[7:1], 1'h0};
		if (ad == 8'h1B) return {v[7:3], 3'h3};
		if (ad == 8'h1C) return 8'hFF;
		return v;
	endfunction

	function automatic logic exp_pol(input logic ovr, input logic pol, input logic ext);
		return ovr ? (ext == pol) : ext;
	endfunction

	task automatic bus_wr(input logic [7:0] ad, input logic [7:0] v);
		@(posedge clk_i);
		if (ce_i && ad >= 8'h18 && ad <= 8'h1E) shadow[ad - 8'h18] = v;
		wr_i <= 1'h1;
		addr_i <= ad;
		wr_data_i <= v;
		@(posedge clk_i);
		wr_i <= 1'h0;
	endtask

	task automatic bus_rd(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge clk_i);
		rd_i <= 1'h1;
		addr_i <= ad;
		@(posedge clk_i);
		rd_i <= 1'h0;
		#1 chk(rd_data_o, exp);
	endtask

	// Falling hsync on channel 0, then clamp delay and width in cycles
	task automatic clamp_run(output int dl, output int wd);
		int j;
		dl = -1;
		wd = 0;
		@(posedge clk_i) chan0_i.hsync <= 1'h1;
		repeat (4) @(posedge clk_i);
		chan0_i.hsync <= 1'h0;
		for (j = 0; j < 700; j++) begin
			@(posedge clk_i);
			#1;
			if (clamp_o === 1'h1 && dl < 0) dl = j;
			if (clamp_o === 1'h1) wd++;
			if (dl >= 0 && clamp_o !== 1'h1) break;
		end
	endtask

	// ==========================================
	// Main sequence
	initial begin
		reset_i = 1'h1;
		ce_i = 1'h1;
		wr_i = 1'h0;
		rd_i = 1'h0;
		addr_i = 8'h00;
		wr_data_i = 8'h00;
		chan0_i = 3'h1;
		chan1_i = 3'h0;
		{ext_clamp_i, ext_freewheel_i, vsync_i, regen_sync_i, filt_sync_i} = 5'h00;
		pl = '{8'h00, 8'h01, 8'hFF, 8'h07};
		du = '{8'h01, 8'hFF, 8'h02, 8'h00};
		ao = '{3'h4, 3'h0, 3'h5, 3'h6};
		nc = '{4, 4, 32, 64};
		ne = '{4, 0, 2, 1};
		ct = '{5'h04, 5'h03, 5'h0F, 5'h06, 5'h1D, 5'h12, 5'h08};
		shadow = '{cso_pkg::RST_FREEWHEEL_CLAMP, cso_pkg::RST_CLAMP_PLACEMENT,
			cso_pkg::RST_CLAMP_DURATION, cso_pkg::RST_CLAMP_OFFSET, cso_pkg::RST_FACTORY_TEST,
			cso_pkg::RST_SLICER, cso_pkg::RST_POWER_CHANNEL};
		void'($urandom(94002));
		repeat (12) @(posedge clk_i);
		reset_i <= 1'h0;
		#1 chk({3'h0, slicer_threshold_o}, 8'h0F);
		chk({7'h00, channel_sel_o}, 8'h00);
		for (k = 0; k < 7; k++) bus_rd(8'h18 + 8'(k), shadow[k]);
		// ==========================================
		// Unmapped places and frozen strobes
		bus_wr(8'h1F, 8'hA5);
		bus_rd(8'h1F, 8'h00);
		bus_rd(8'h17, 8'h00);
		@(posedge clk_i) ce_i <= 1'h0;
		bus_wr(8'h19, 8'hAA);
		@(posedge clk_i) ce_i <= 1'h1;
		bus_rd(8'h19, shadow[1]);
		// Write then read with no gap between strobes
		@(posedge clk_i);
		wr_i <= 1'h1;
		addr_i <= 8'h19;
		wr_data_i <= 8'h5C;
		@(posedge clk_i);
		wr_i <= 1'h0;
		rd_i <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		shadow[1] = 8'h5C;
		#1 chk(rd_data_o, 8'h5C);
		// ==========================================
		// Random readback and field outputs
		for (i = 0; i < 40; i++) begin
			a = 8'h18 + 8'($urandom % 7);
			d = legal(a, 8'($urandom));
			bus_wr(a, d);
			bus_rd(a, shadow[a - 8'h18]);
			chk({5'h00, clamp_level_o}, {5'h00, shadow[0][3:1]});
			chk({3'h0, slicer_threshold_o}, {3'h0, shadow[5][7:3]});
			chk({7'h00, auto_offset_en_o}, {7'h00, shadow[3][5]});
		end
		// ==========================================
		// Internal clamp placement and duration
		bus_wr(8'h18, 8'h20);
		bus_wr(8'h1E, 8'h30);
		bus_wr(8'h19, 8'h03);
		bus_wr(8'h1A, 8'h05);
		clamp_run(dly, wid);
		base = dly - 3;
		// Pin to clamp latency: two sync stages, edge detect, registered output
		chk(8'(base), 8'h03);
		chk(8'(wid), 8'h05);
		for (k = 0; k < 4; k++) begin
			bus_wr(8'h19, pl[k]);
			bus_wr(8'h1A, du[k]);
			clamp_run(dly, wid);
			if (du[k] != 8'h00) chk(8'(dly - base), pl[k]);
			chk(8'(wid), du[k]);
		end
		// ==========================================
		// Auto-offset update rates
		bus_wr(8'h19, 8'h01);
		bus_wr(8'h1A, 8'h02);
		for (k = 0; k < 4; k++) begin
			bus_wr(8'h1B, {2'h1, ao[k], 3'h3});
			n_upd = 0;
			repeat (nc[k]) clamp_run(dly, wid);
			repeat (5) @(posedge clk_i);
			chk(8'(n_upd), 8'(ne[k]));
		end
		bus_wr(8'h1B, 8'h3B);
		n_upd = 0;
		repeat (3) begin
			@(posedge clk_i) vsync_i <= 1'h1;
			repeat (5) @(posedge clk_i);
			vsync_i <= 1'h0;
			repeat (5) @(posedge clk_i);
		end
		chk(8'(n_upd), 8'h03);
		// ==========================================
		// Embedded sync output source and polarity
		for (k = 0; k < 8; k++) begin
			r = 5'($urandom);
			@(posedge clk_i);
			chan0_i <= {r[0], r[1], 1'h1};
			chan1_i <= {~r[0], ~r[1], 1'h0};
			regen_sync_i <= r[2];
			filt_sync_i <= r[3];
			bus_wr(8'h1D, {r, k[2], k[1:0]});
			repeat (6) @(posedge clk_i);
			d = {7'h00, exp_pol(1'h1, k[2], k[1] ? (k[0] ? r[3] : r[2]) : (k[0] ? r[0] : r[1]))};
			chk({7'h00, embedded_sync_output_o}, d);
			chk({3'h0, slicer_threshold_o}, {3'h0, r});
		end
		// ==========================================
		// Channel choice
		for (k = 0; k < 7; k++) begin
			@(posedge clk_i);
			chan0_i.sync_present <= ct[k][2];
			chan1_i.sync_present <= ct[k][1];
			bus_wr(8'h1E, {ct[k][4:3], 6'h30});
			repeat (6) @(posedge clk_i);
			chk({7'h00, channel_sel_o}, {7'h00, ct[k][0]});
		end
		// ==========================================
		// Freewheel and external clamp polarity
		for (k = 0; k < 32; k++) begin
			r = 5'($urandom);
			@(posedge clk_i);
			ext_freewheel_i <= k[1];
			ext_clamp_i <= k[0];
			vsync_i <= k[0];
			bus_wr(8'h18, {k[4:2], 1'h1, r[2:0], 1'h0});
			bus_wr(8'h1B, {k[3:2], 3'h3, 3'h3});
			repeat (6) @(posedge clk_i);
			d = {7'h00, k[4] ? exp_pol(k[3], k[2], k[1]) : k[0]};
			chk({7'h00, pll_freewheel_o}, d);
			chk({7'h00, clamp_o}, {7'h00, exp_pol(k[3], k[2], k[0])});
			chk({5'h00, clamp_level_o}, {5'h00, r[2:0]});
		end
		print_verdict();
	end
endmodule
